// file: hfs_load_model.sv
// Behavioural Hall line that turns a fault code into sensed levels
`timescale 1ns/1ps
module hfs_load_model
  (
  input  wire hfs_pkg::hfs_drive_t drive,
  input  wire logic [1:0]          fault,
  input  wire logic                hall,
  output      hfs_pkg::hfs_sense_t sense
  );
  import hfs_pkg::*;
  assign sense.open_load = fault == 2'h1;
  assign sense.short_bat = fault == 2'h2;
  // line shorted low draws too much
  assign sense.short_gnd = fault == 2'h3;
  // No supply current, so no Hall reading
  assign sense.hall_high = hall & drive.supply_on;
endmodule : hfs_load_model

// file: hfs_pkg.sv
// Shared types and constants for the Hall input fault supervisor
package hfs_pkg;

  // Blanking time, 80 us at 200 MHz
  localparam int BLANK_NS      = 80000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int BLANK_CYCLES  = BLANK_NS / CLK_PERIOD_NS;

  // Reset values of the pin-side outputs
  localparam logic RST_FLAG_N = 1'h1;
  localparam logic RST_LEVEL  = 1'h0;

  // Channel condition, as sensed by the analog front end
  typedef struct packed {
    logic open_load;   // Current below 2 mA
    logic short_bat;   // Input above the battery supply
    logic short_gnd;   // Current above 23 mA
    logic hall_high;   // Filtered Hall switch state
  } hfs_sense_t;

  // Per-channel drive controls toward the analog front end
  typedef struct packed {
    logic supply_on;   // Full sensor supply current
    logic pullup_on;   // 50 uA pullup only
  } hfs_drive_t;

  typedef enum logic [1:0] {
    HFS_RUN,
    HFS_BLANK,
    HFS_OFF,
    HFS_GND_LOCK
  } hfs_state_t;

endpackage : hfs_pkg

// file: hfs_supervisor.sv
// Fault supervision, shutoff and restart for two Hall switch inputs
//
// How it works
// - A battery supply outside 6 V to 18 V cuts both channels and, with select_a low, pulls the fault flag low.
// - When the supply is valid again both channels restart through blanking.
// - An open channel (below 2 mA) flags a fault, is cut, and restarts with blanking once loaded.
// - An input above the battery supply flags a fault and cuts only that channel.
// - Above 23 mA the channel flags a fault, is cut and keeps only its pullup.
// - A falling edge on select_a restarts every ground-shorted channel with blanking.
// - The ground-short shutoff holds until restarted; every other fault clears itself.
// - Only the ground-short lock and the blanking count are stored; all other reporting follows the present condition each cycle.
// - With select_a high, faults are coded on the flag and levels; supply fault or blanking dominates.
`timescale 1ns/1ps
module hfs_supervisor
  #(parameter int BLANK_LEN = hfs_pkg::BLANK_CYCLES)
  (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               clk_en,
  input  wire logic               bat_in_range,
  input  wire logic               select_a,
  input  wire hfs_pkg::hfs_sense_t sense_1,
  input  wire hfs_pkg::hfs_sense_t sense_2,
  output      hfs_pkg::hfs_drive_t drive_1,
  output      hfs_pkg::hfs_drive_t drive_2,
  output      logic               fault_flag_n,
  output      logic               hall_level_1,
  output      logic               hall_level_2
  );
  import hfs_pkg::*;

  // The blanking counter is 16 bits wide
  if (BLANK_LEN < 1 || BLANK_LEN > 65535) begin : g_bad_len
    $error("BLANK_LEN out of range");
  end

  // Pins arrive asynchronously: two flops before any logic reads them
  logic [11:0] sync_a;
  logic [11:0] sync_b;
  wire  [11:0] pins = {bat_in_range, select_a, sense_1, sense_2,
                       2'h0};
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_a <= 12'h000;
      sync_b <= 12'h000;
    end else if (clk_en) begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  wire        bat_ok = sync_b[11];
  wire        sel    = sync_b[10];
  hfs_sense_t s1;
  hfs_sense_t s2;
  assign s1 = sync_b[9:6];
  assign s2 = sync_b[5:2];

  logic sel_d;
  always_ff @(posedge clock) begin
    if (rst)
      sel_d <= 1'h0;
    else if (clk_en)
      sel_d <= sel;
  end
  wire sel_fall = sel_d & ~sel;

  hfs_state_t st   [2];
  logic [15:0] cnt [2];
  hfs_sense_t sv   [2];
  assign sv[0] = s1;
  assign sv[1] = s2;

  function automatic hfs_state_t next_of(input hfs_state_t cur,
                                         input hfs_sense_t s,
                                         input logic ok,
                                         input logic fall,
                                         input logic done);
    hfs_state_t n;
    n = cur;
    case (cur)
      HFS_RUN, HFS_BLANK: begin
        if (!ok || s.open_load || s.short_bat)
          n = HFS_OFF;
        else if (s.short_gnd)
          n = HFS_GND_LOCK;
        else if (cur == HFS_BLANK && done)
          n = HFS_RUN;
      end
      HFS_OFF: begin
        if (ok && !s.open_load && !s.short_bat)
          n = HFS_BLANK;
      end
      HFS_GND_LOCK: begin
        // Held until select_a falls, the line opens, or the supply fails
        if (!ok)
          n = HFS_OFF;
        else if (fall || s.open_load)
          n = HFS_BLANK;
      end
      default: n = HFS_OFF;
    endcase
    return n;
  endfunction : next_of

  hfs_state_t next_st [2];
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign next_st[i] = next_of(st[i], sv[i], bat_ok, sel_fall,
                                cnt[i] == 16'(BLANK_LEN - 1));
    always_ff @(posedge clock) begin
      if (rst) begin
        st[i]  <= HFS_OFF;
        cnt[i] <= 16'h0000;
      end else if (clk_en) begin
        st[i] <= next_st[i];
        if (next_st[i] == HFS_BLANK && st[i] == HFS_BLANK)
          cnt[i] <= cnt[i] + 16'h0001;
        else
          cnt[i] <= 16'h0000;
      end
    end
  end

  // Two-bit code: 00 none/blank, 01 open, 10 battery, 11 ground
  function automatic logic [1:0] code_of(input hfs_state_t st_c,
                                         input hfs_sense_t s);
    logic [1:0] c;
    c = 2'h0;
    if (st_c == HFS_GND_LOCK)
      c = 2'h3;
    else if (s.short_bat)
      c = 2'h2;
    else if (s.open_load)
      c = 2'h1;
    return c;
  endfunction : code_of

  wire bad_1 = st[0] != HFS_RUN;
  wire bad_2 = st[1] != HFS_RUN;
  wire [1:0] code_1 = code_of(st[0], s1);
  wire [1:0] code_2 = code_of(st[1], s2);
  wire blank_any = st[0] == HFS_BLANK || st[1] == HFS_BLANK;
  // Supply fault or blanking dominates every other code
  wire dominant = !bat_ok || blank_any;
  wire ch1_coded = code_1 != 2'h0;

  logic next_flag_n;
  logic next_l1;
  logic next_l2;
  always_comb begin
    next_flag_n = 1'h1;
    next_l1     = 1'h0;
    next_l2     = 1'h0;
    if (sel) begin
      if (dominant) begin
        next_flag_n = 1'h1;
      end else if (ch1_coded) begin
        next_flag_n = 1'h0;
        {next_l1, next_l2} = code_1;
      end else if (code_2 != 2'h0) begin
        next_flag_n = 1'h1;
        {next_l1, next_l2} = code_2;
      end else begin
        next_flag_n = 1'h0;
      end
    end else begin
      // Live levels, gated by supply faults and by any channel state other than HFS_RUN
      next_flag_n = !(bad_1 || bad_2 || !bat_ok);
      next_l1     = !bad_1 && bat_ok && s1.hall_high;
      next_l2     = !bad_2 && bat_ok && s2.hall_high;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fault_flag_n <= RST_FLAG_N;
      hall_level_1 <= RST_LEVEL;
      hall_level_2 <= RST_LEVEL;
      drive_1      <= '0;
      drive_2      <= '0;
    end else if (clk_en) begin
      fault_flag_n <= next_flag_n;
      hall_level_1 <= next_l1;
      hall_level_2 <= next_l2;
      // Ground short keeps only the pullup
      drive_1 <= '{supply_on: next_st[0] inside {HFS_RUN, HFS_BLANK},
                  pullup_on: next_st[0] == HFS_GND_LOCK};
      drive_2 <= '{supply_on: next_st[1] inside {HFS_RUN, HFS_BLANK},
                  pullup_on: next_st[1] == HFS_GND_LOCK};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !clk_en);

  sequence s_gnd_fall;
    st[0] == HFS_GND_LOCK && bat_ok && !s1.open_load ##0 sel_fall;
  endsequence

  a_bat_cuts_both: assert property (
    !bat_ok |=> !drive_1.supply_on && !drive_2.supply_on)
    else $error("supply fault did not cut both channels");
  a_bat_flag_low: assert property (
    !bat_ok && !sel |=> !fault_flag_n)
    else $error("supply fault did not lower the flag");
  a_restart_blank: assert property (
    st[0] == HFS_OFF |=> st[0] != HFS_RUN)
    else $error("channel left shutoff without blanking");
  a_open_cuts: assert property (
    st[0] == HFS_RUN && s1.open_load |=> st[0] == HFS_OFF &&
    !drive_1.supply_on)
    else $error("open channel not cut");
  a_bat_short_one: assert property (
    st[0] == HFS_RUN && s1.short_bat && st[1] == HFS_RUN && bat_ok
    && sv[1] == 4'h0 |=> st[1] == HFS_RUN)
    else $error("battery short cut the other channel");
  a_gnd_pullup: assert property (
    st[0] == HFS_GND_LOCK |-> drive_1.pullup_on && !drive_1.supply_on)
    else $error("ground short did not leave pullup only");
  a_gnd_restart: assert property (
    s_gnd_fall |=> st[0] == HFS_BLANK)
    else $error("falling select_a did not restart channel");
  a_gnd_holds: assert property (
    st[0] == HFS_GND_LOCK && !sel_fall && bat_ok && !s1.open_load
    |=> st[0] == HFS_GND_LOCK)
    else $error("ground short released on its own");
  a_blank_len: assert property (
    st[0] == HFS_BLANK && cnt[0] == 16'(BLANK_LEN - 1) && bat_ok
    && sv[0] == 4'h0 |=> st[0] == HFS_RUN)
    else $error("blanking did not end on time");
  a_blank_flag: assert property (
    st[0] == HFS_BLANK && !sel |=> !fault_flag_n)
    else $error("blanking channel not reported as faulted");

endmodule : hfs_supervisor

// file: testbench.sv
// Self-checking bench for the Hall input fault supervisor
`timescale 1ns/1ps
module testbench;
  import hfs_pkg::*;
  logic        clock    = 1'h0;
  logic        rst      = 1'h1;
  logic        bat_ok   = 1'h1;
  logic        select_a = 1'h0;
  logic [1:0]  flt [1:2];
  logic [1:2]  hall     = 2'h0;
  logic [31:0] seed     = 32'h3;
  hfs_sense_t  sense_1;
  hfs_sense_t  sense_2;
  hfs_drive_t  drive_1;
  hfs_drive_t  drive_2;
  logic        fault_flag_n;
  logic        hall_level_1;
  logic        hall_level_2;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  wire [6:0]   snap = {fault_flag_n, hall_level_1, hall_level_2,
                       drive_1, drive_2};

  always #2.5 clock = ~clock;

  hfs_supervisor #(.BLANK_LEN(8)) dut (.clock(clock), .rst(rst),
    .clk_en(1'h1), .bat_in_range(bat_ok), .select_a(select_a),
    .sense_1(sense_1), .sense_2(sense_2), .drive_1(drive_1),
    .drive_2(drive_2), .fault_flag_n(fault_flag_n),
    .hall_level_1(hall_level_1), .hall_level_2(hall_level_2));
  hfs_load_model ld1 (.drive(drive_1), .fault(flt[1]), .hall(hall[1]),
    .sense(sense_1));
  hfs_load_model ld2 (.drive(drive_2), .fault(flt[2]), .hall(hall[2]),
    .sense(sense_2));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Flag low and the cut channel's drives; the other keeps full supply
  function automatic logic [6:0] exp_cut(input int ch, input int c);
    logic [1:0] d;
    d = {1'h0, c == 3};
    return (ch == 1) ? {3'h0, d, 2'h2} : {3'h0, 2'h2, d};
  endfunction : exp_cut

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %b want %b", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    flt[1] = 2'h0;
    flt[2] = 2'h0;
    cyc(12);
    check(snap, 7'h40);
    rst = 1'h0;
    cyc(25);
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      hall = seed[1:0];
      cyc(5);
      check(snap, {1'h1, seed[1:0], 4'hA});
    end
    bat_ok = 1'h0;
    cyc(5);
    check(snap, 7'h00);
    bat_ok = 1'h1;
    cyc(5);
    check(snap & 7'h70, 7'h00);
    cyc(20);
    check(snap, {1'h1, hall, 4'hA});
    // Every fault kind on each channel, then its recovery
    for (int ch = 1; ch <= 2; ch++) begin
      for (int c = 1; c <= 3; c++) begin
        flt[ch] = c[1:0];
        cyc(6);
        check(snap & 7'h4F, exp_cut(ch, c));
        select_a = 1'h1;
        cyc(5);
        check(snap & 7'h70, {ch == 2, c[1:0], 4'h0});
        flt[ch] = 2'h0;
        cyc(25);
        // only the ground short stays cut
        check(snap & 7'h0F, (c == 3 ? exp_cut(ch, c) : 7'h0A) & 7'h0F);
        select_a = 1'h0;
        cyc(25);
        check(snap & 7'h4F, 7'h4A);
      end
    end
    select_a = 1'h1;
    cyc(5);
    check(snap & 7'h70, 7'h00);
    give_verdict();
  end

  initial begin
    #50000;
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
